//--- sleep_gating_pkg.sv
// Package with register map, field layout, modes, states and timing counts
package sleep_gating_pkg;

  // Register indices and byte addresses (byte address is four times the index)
  localparam logic [7:0] CTRL_INDEX = 8'h35;
  localparam logic [7:0] GATE_INDEX = 8'h36;
  localparam logic [9:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
  localparam logic [9:0] GATE_ADDR = {GATE_INDEX, 2'b00};

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] GATE_RESET = 8'h00;

  // Control register fields
  localparam int MISC_HI_POS = 6;
  localparam int ARM_POS = 5;
  localparam int MODE_HI_POS = 4;
  localparam int MODE_LO_POS = 3;
  localparam int MISC_B1_POS = 1;
  localparam int MISC_B0_POS = 0;

  // Gating register fields
  localparam int GATE_TIMER_ONE_POS = 3;
  localparam int GATE_TIMER_ZERO_POS = 2;
  localparam int GATE_SERIAL_POS = 1;
  localparam int GATE_CONVERTER_POS = 0;
  localparam int GATE_WIDTH = 4;

  // Timing in clock cycles
  localparam logic [3:0] STANDBY_WAKE_CYCLES = 4'h6;
  localparam logic [3:0] WAKE_HALT_CYCLES = 4'h4;
  localparam logic [3:0] OSC_STARTUP_CYCLES = 4'hf;

  // Sleep mode encodings
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_NOISE = 2'b01,
    MODE_POWER_DOWN = 2'b10,
    MODE_STANDBY = 2'b11
  } sleep_mode_e;

  // Sequencer states, Gray along active -> asleep -> startup -> halt
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_ASLEEP = 2'b01,
    ST_STARTUP = 2'b11,
    ST_HALT = 2'b10
  } seq_state_e;

endpackage

//--- sleep_mode_power_gating.sv
// Sleep-mode sequencer and per-peripheral clock gating with an APB register slave
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module sleep_mode_power_gating #(
  parameter logic [3:0] STARTUP_CYCLES = sleep_gating_pkg::OSC_STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side
  input wire logic sleep_exec,
  input wire logic crystal_selected,
  output logic cpu_resume,
  // Wake requests already qualified by the interrupt controller
  input wire logic any_irq,
  input wire logic converter_done_irq,
  input wire logic self_program_store_ready_irq,
  // Wake pins from outside the clock domain
  input wire logic external_line_zero_level,
  input wire logic pin_change,
  // Analog and supervisor status
  input wire logic converter_enabled,
  input wire logic conversion_started,
  input wire logic comparator_enabled,
  input wire logic comparator_uses_reference,
  input wire logic brownout_level_fuse,
  input wire logic watchdog_enabled,
  // Clock enables
  output logic clk_en_cpu,
  output logic clk_en_flash,
  output logic clk_en_io,
  output logic clk_en_converter,
  output logic clk_en_timer_one,
  output logic clk_en_timer_zero,
  output logic clk_en_serial,
  output logic osc_enable,
  // Peripheral register access blocked while gated
  output logic [3:0] periph_access_block,
  // Analog and supervisor controls
  output logic converter_auto_start,
  output logic converter_extended_next,
  output logic comparator_active,
  output logic reference_enable,
  output logic brownout_active,
  output logic watchdog_run,
  output logic digital_input_enable,
  output logic [2:0] misc_ctrl
);

  // Whole module state in one record
  typedef struct packed {
    sleep_gating_pkg::seq_state_e state;
    logic [1:0] mode;
    logic arm;
    logic [2:0] misc;
    logic [3:0] gate;
    logic [3:0] count;
    logic [2:0] sync_line;
    logic [2:0] sync_pin;
    logic line_lvl;
    logic pin_lvl;
    logic conv_prev;
    logic ext_next;
    logic auto_start;
    logic resume;
    logic [7:0] clk_en;
    logic [3:0] block;
    logic comp_on;
    logic ref_on;
    logic bod_on;
    logic wdt_on;
    logic din_en;
    logic [31:0] rdata;
  } regs_s;

  regs_s cur;
  regs_s next_cur;

  logic apb_access;
  logic hit_ctrl;
  logic hit_gate;

  // Slave answers in the first access cycle, so no wait states
  assign apb_access = psel && penable;
  assign hit_ctrl = (paddr == sleep_gating_pkg::CTRL_ADDR);
  assign hit_gate = (paddr == sleep_gating_pkg::GATE_ADDR);
  assign pready = 1'b1;
  assign pslverr = apb_access && !hit_ctrl && !hit_gate;

  // Registered outputs
  assign prdata = cur.rdata;
  assign cpu_resume = cur.resume;
  assign clk_en_cpu = cur.clk_en[0];
  assign clk_en_flash = cur.clk_en[1];
  assign clk_en_io = cur.clk_en[2];
  assign clk_en_converter = cur.clk_en[3];
  assign clk_en_timer_one = cur.clk_en[4];
  assign clk_en_timer_zero = cur.clk_en[5];
  assign clk_en_serial = cur.clk_en[6];
  assign osc_enable = cur.clk_en[7];
  assign periph_access_block = cur.block;
  assign converter_auto_start = cur.auto_start;
  assign converter_extended_next = cur.ext_next;
  assign comparator_active = cur.comp_on;
  assign reference_enable = cur.ref_on;
  assign brownout_active = cur.bod_on;
  assign watchdog_run = cur.wdt_on;
  assign digital_input_enable = cur.din_en;
  assign misc_ctrl = cur.misc;

  // Next-state logic for the whole block
  always_comb begin
    logic [1:0] eff_mode;
    logic asleep;
    logic wake;
    logic deep;
    logic run_cpu;
    logic run_io;
    logic run_conv;
    logic run_osc;
    eff_mode = 2'b00;
    asleep = 1'b0;
    wake = 1'b0;
    deep = 1'b0;
    run_cpu = 1'b0;
    run_io = 1'b0;
    run_conv = 1'b0;
    run_osc = 1'b0;
    next_cur = cur;
    next_cur.auto_start = 1'b0;
    next_cur.resume = 1'b0;

    // Wake pins: three flops, a change counts once the last two agree
    next_cur.sync_line = {cur.sync_line[1:0], external_line_zero_level};
    next_cur.sync_pin = {cur.sync_pin[1:0], pin_change};
    if (cur.sync_line[2] == cur.sync_line[1]) begin
      next_cur.line_lvl = cur.sync_line[2];
    end
    if (cur.sync_pin[2] == cur.sync_pin[1]) begin
      next_cur.pin_lvl = cur.sync_pin[2];
    end

    // Standby needs a crystal, otherwise mode 11 falls back to power-down
    eff_mode = cur.mode;
    if (cur.mode == sleep_gating_pkg::MODE_STANDBY && !crystal_selected) begin
      eff_mode = sleep_gating_pkg::MODE_POWER_DOWN;
    end

    // Wake qualification per mode
    case (eff_mode)
      sleep_gating_pkg::MODE_IDLE: begin
        wake = any_irq;
      end
      sleep_gating_pkg::MODE_NOISE: begin
        wake = converter_done_irq || self_program_store_ready_irq
          || cur.line_lvl || cur.pin_lvl;
      end
      default: begin
        wake = cur.line_lvl || cur.pin_lvl;
      end
    endcase

    // Sleep sequencer
    case (cur.state)
      sleep_gating_pkg::ST_ACTIVE: begin
        if (sleep_exec && cur.arm) begin
          next_cur.state = sleep_gating_pkg::ST_ASLEEP;
          next_cur.auto_start = (eff_mode == sleep_gating_pkg::MODE_NOISE) && converter_enabled;
        end
      end
      sleep_gating_pkg::ST_ASLEEP: begin
        if (wake) begin
          if (eff_mode == sleep_gating_pkg::MODE_STANDBY) begin
            next_cur.state = sleep_gating_pkg::ST_STARTUP;
            next_cur.count = sleep_gating_pkg::STANDBY_WAKE_CYCLES - 4'h1;
          end else if (eff_mode == sleep_gating_pkg::MODE_POWER_DOWN) begin
            next_cur.state = sleep_gating_pkg::ST_STARTUP;
            next_cur.count = STARTUP_CYCLES - 4'h1;
          end else begin
            next_cur.state = sleep_gating_pkg::ST_HALT;
            next_cur.count = sleep_gating_pkg::WAKE_HALT_CYCLES - 4'h1;
          end
        end
      end
      sleep_gating_pkg::ST_STARTUP: begin
        if (cur.count == 4'h0) begin
          next_cur.state = sleep_gating_pkg::ST_HALT;
          next_cur.count = sleep_gating_pkg::WAKE_HALT_CYCLES - 4'h1;
        end else begin
          next_cur.count = cur.count - 4'h1;
        end
      end
      sleep_gating_pkg::ST_HALT: begin
        if (cur.count == 4'h0) begin
          next_cur.state = sleep_gating_pkg::ST_ACTIVE;
          next_cur.resume = 1'b1;
        end else begin
          next_cur.count = cur.count - 4'h1;
        end
      end
      default: begin
        next_cur.state = sleep_gating_pkg::ST_ACTIVE;
      end
    endcase

    // APB writes; the CPU is stopped while asleep so none arrive then
    if (apb_access && pwrite && hit_ctrl) begin
      next_cur.arm = pwdata[sleep_gating_pkg::ARM_POS];
      next_cur.mode = pwdata[sleep_gating_pkg::MODE_HI_POS:sleep_gating_pkg::MODE_LO_POS];
      next_cur.misc = {pwdata[sleep_gating_pkg::MISC_HI_POS], pwdata[sleep_gating_pkg::MISC_B1_POS],
                       pwdata[sleep_gating_pkg::MISC_B0_POS]};
    end
    if (apb_access && pwrite && hit_gate) begin
      next_cur.gate = pwdata[sleep_gating_pkg::GATE_WIDTH-1:0];
    end

    // APB read data, reserved bits zero
    next_cur.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite && hit_ctrl) begin
      next_cur.rdata[sleep_gating_pkg::MISC_HI_POS] = cur.misc[2];
      next_cur.rdata[sleep_gating_pkg::ARM_POS] = cur.arm;
      next_cur.rdata[sleep_gating_pkg::MODE_HI_POS:sleep_gating_pkg::MODE_LO_POS] = cur.mode;
      next_cur.rdata[sleep_gating_pkg::MISC_B1_POS] = cur.misc[1];
      next_cur.rdata[sleep_gating_pkg::MISC_B0_POS] = cur.misc[0];
    end else if (psel && !penable && !pwrite && hit_gate) begin
      next_cur.rdata[sleep_gating_pkg::GATE_WIDTH-1:0] = cur.gate;
    end

    // Converter on-then-off marks next conversion extended; set beats clear
    next_cur.conv_prev = converter_enabled;
    if (conversion_started) begin
      next_cur.ext_next = 1'b0;
    end
    if (cur.conv_prev && !converter_enabled) begin
      next_cur.ext_next = 1'b1;
    end

    // Domain clock enables from the next state, so outputs stay registered
    asleep = (next_cur.state != sleep_gating_pkg::ST_ACTIVE);
    deep = asleep && (eff_mode[1] == 1'b1);
    run_cpu = (next_cur.state == sleep_gating_pkg::ST_ACTIVE);
    run_io = !asleep || (next_cur.state == sleep_gating_pkg::ST_HALT)
      || (eff_mode == sleep_gating_pkg::MODE_IDLE);
    run_conv = run_io || (eff_mode == sleep_gating_pkg::MODE_NOISE);
    run_osc = !asleep || (next_cur.state == sleep_gating_pkg::ST_STARTUP)
      || (next_cur.state == sleep_gating_pkg::ST_HALT) || !deep
      || (eff_mode == sleep_gating_pkg::MODE_STANDBY);
    if (deep && next_cur.state == sleep_gating_pkg::ST_STARTUP) begin
      run_io = 1'b0;
      run_conv = 1'b0;
    end

    // Peripheral gating layered on the domain enables; gating freezes, not resets
    next_cur.clk_en[0] = run_cpu;
    next_cur.clk_en[1] = run_cpu;
    next_cur.clk_en[2] = run_io;
    next_cur.clk_en[3] = run_conv && !next_cur.gate[sleep_gating_pkg::GATE_CONVERTER_POS];
    next_cur.clk_en[4] = run_io && !next_cur.gate[sleep_gating_pkg::GATE_TIMER_ONE_POS];
    next_cur.clk_en[5] = run_io && !next_cur.gate[sleep_gating_pkg::GATE_TIMER_ZERO_POS];
    next_cur.clk_en[6] = run_io && !next_cur.gate[sleep_gating_pkg::GATE_SERIAL_POS];
    next_cur.clk_en[7] = run_osc;
    next_cur.block = next_cur.gate;

    // Analog and supervisor controls
    next_cur.comp_on = comparator_enabled && !deep;
    next_cur.ref_on = brownout_level_fuse || (comparator_enabled && comparator_uses_reference)
      || converter_enabled;
    next_cur.bod_on = brownout_level_fuse;
    next_cur.wdt_on = watchdog_enabled;
    next_cur.din_en = run_io || run_conv;
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '{
        state: sleep_gating_pkg::ST_ACTIVE,
        mode: sleep_gating_pkg::CTRL_RESET[sleep_gating_pkg::MODE_HI_POS:sleep_gating_pkg::MODE_LO_POS],
        arm: sleep_gating_pkg::CTRL_RESET[sleep_gating_pkg::ARM_POS],
        misc: 3'h0,
        gate: sleep_gating_pkg::GATE_RESET[3:0],
        count: 4'h0,
        sync_line: 3'h0,
        sync_pin: 3'h0,
        line_lvl: 1'b0,
        pin_lvl: 1'b0,
        conv_prev: 1'b0,
        ext_next: 1'b0,
        auto_start: 1'b0,
        resume: 1'b0,
        clk_en: 8'hff,
        block: 4'h0,
        comp_on: 1'b0,
        ref_on: 1'b0,
        bod_on: 1'b0,
        wdt_on: 1'b0,
        din_en: 1'b1,
        rdata: 32'h0000_0000
      };
    end else begin
      cur <= next_cur;
    end
  end

endmodule

`default_nettype wire

//--- sleep_gating_props.sv
// Checker for the sleep sequencer and peripheral clock gating ports
`timescale 1ns/10ps
`default_nettype none
module sleep_gating_props #(
  parameter logic [3:0] STARTUP_CYCLES = sleep_gating_pkg::OSC_STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic sleep_exec,
  input wire logic crystal_selected,
  input wire logic converter_enabled,
  input wire logic brownout_level_fuse,
  input wire logic watchdog_enabled,
  input wire logic clk_en_cpu,
  input wire logic clk_en_flash,
  input wire logic clk_en_io,
  input wire logic clk_en_converter,
  input wire logic osc_enable,
  input wire logic [3:0] periph_access_block,
  input wire logic converter_auto_start,
  input wire logic brownout_active,
  input wire logic watchdog_run
);
  logic [2:0] ctl;
  logic [3:0] gt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Shadow of arm, mode and gating bits; a write lands at its access edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl <= 3'h0;
      gt <= 4'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == sleep_gating_pkg::CTRL_ADDR) ctl <= pwdata[5:3];
      if (paddr == sleep_gating_pkg::GATE_ADDR) gt <= pwdata[3:0];
    end
  end
  // Running CPU plus armed sleep in a given mode
  property p_enter(logic [1:0] m, logic ok);
    sleep_exec && ctl == {1'b1, m} && clk_en_cpu |=> ok;
  endproperty
  AST_IDLE_ENTRY: assert property (p_enter(2'h0, !clk_en_cpu && !clk_en_flash && clk_en_io && clk_en_converter))
    else $error("idle entry clocks wrong");
  AST_NOISE_ENTRY: assert property (p_enter(2'h1, !clk_en_cpu && !clk_en_io && clk_en_converter))
    else $error("noise entry clocks wrong");
  AST_PDOWN_ENTRY: assert property (p_enter(2'h2, !osc_enable && !clk_en_io && !clk_en_converter))
    else $error("power-down entry clocks wrong");
  AST_STBY_ENTRY: assert property (sleep_exec && ctl == 3'h7 && crystal_selected && clk_en_cpu |=>
    osc_enable && !clk_en_io && !clk_en_cpu) else $error("standby entry clocks wrong");
  AST_ARM_OFF_NOP: assert property (sleep_exec && !ctl[2] && clk_en_cpu |=> clk_en_cpu[*2] ##0 osc_enable)
    else $error("sleep without arm stopped clocks");
  AST_AUTO_START: assert property (sleep_exec && ctl == 3'h5 && clk_en_cpu && converter_enabled |=>
    converter_auto_start) else $error("no conversion start on noise entry");
  AST_GATE_BLOCK: assert property (gt == $past(gt) |-> periph_access_block == gt)
    else $error("access block differs from gating bits");
  AST_WDT_RUN: assert property (!$past(sys_rst) |-> watchdog_run == $past(watchdog_enabled))
    else $error("watchdog run does not follow enable");
  AST_BOD_ACTIVE: assert property (!$past(sys_rst) |-> brownout_active == $past(brownout_level_fuse))
    else $error("brown-out active does not follow fuse");
  // Main scenarios reached
  cover property (sleep_exec && ctl[2] && clk_en_cpu);
  cover property (converter_auto_start);
  cover property (periph_access_block == 4'hf);
endmodule
bind sleep_mode_power_gating sleep_gating_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .sleep_exec(sleep_exec), .crystal_selected(crystal_selected),
  .converter_enabled(converter_enabled), .brownout_level_fuse(brownout_level_fuse),
  .watchdog_enabled(watchdog_enabled), .clk_en_cpu(clk_en_cpu), .clk_en_flash(clk_en_flash),
  .clk_en_io(clk_en_io), .clk_en_converter(clk_en_converter), .osc_enable(osc_enable),
  .periph_access_block(periph_access_block), .converter_auto_start(converter_auto_start),
  .brownout_active(brownout_active), .watchdog_run(watchdog_run));
`default_nettype wire

//--- cpu_side_model.sv
// CPU and wake pin model on the far side of the sleep block
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model (
  input wire logic clk,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic clk_en_cpu,
  output logic sleep_exec,
  output logic external_line_zero_level
);
  // Sleep instruction only issues while the CPU clock runs; one driver per output
  always @(posedge clk) sleep_exec <= sleep_req && clk_en_cpu;
  // Level wake held until the bench sees the CPU resume, not a short blip
  always @(posedge clk) external_line_zero_level <= wake_req;
endmodule
`default_nettype wire

//--- test_sleep_mode_power_gating.sv
// Self-checking bench for the sleep sequencer and clock gating block
`timescale 1ns/10ps
`default_nettype none
module test_sleep_mode_power_gating;
  logic clk, sys_rst, psel, penable, pwrite, sleep_req, wake_req, any_irq, crystal_selected;
  logic converter_enabled, comparator_enabled, brownout_level_fuse, watchdog_enabled, sleep_exec, ext_lvl;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, serr, cpu_resume, clk_en_cpu, clk_en_flash, clk_en_io, clk_en_converter, osc_enable;
  logic clk_en_timer_one, clk_en_timer_zero, clk_en_serial, converter_auto_start, converter_extended_next;
  logic comparator_active, reference_enable, brownout_active, watchdog_run, digital_input_enable, auto_seen;
  logic [3:0] periph_access_block;
  logic [2:0] misc_ctrl;
  logic conv_start;
  int err_count, tests_run, cyc;
  int t[4];
  localparam logic [4:0] EXP_EN[4] = '{5'h07, 5'h03, 5'h00, 5'h01};
  // Short start-up keeps power-down wake quick
  sleep_mode_power_gating #(.STARTUP_CYCLES(4'h2)) i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_exec(sleep_exec), .crystal_selected(crystal_selected), .cpu_resume(cpu_resume),
    .any_irq(any_irq), .converter_done_irq(1'b0), .self_program_store_ready_irq(1'b0),
    .external_line_zero_level(ext_lvl), .pin_change(1'b0), .converter_enabled(converter_enabled),
    .conversion_started(conv_start), .comparator_enabled(comparator_enabled), .comparator_uses_reference(1'b0),
    .brownout_level_fuse(brownout_level_fuse), .watchdog_enabled(watchdog_enabled), .clk_en_cpu(clk_en_cpu),
    .clk_en_flash(clk_en_flash), .clk_en_io(clk_en_io), .clk_en_converter(clk_en_converter),
    .clk_en_timer_one(clk_en_timer_one), .clk_en_timer_zero(clk_en_timer_zero), .clk_en_serial(clk_en_serial),
    .osc_enable(osc_enable), .periph_access_block(periph_access_block),
    .converter_auto_start(converter_auto_start), .converter_extended_next(converter_extended_next),
    .comparator_active(comparator_active), .reference_enable(reference_enable),
    .brownout_active(brownout_active), .watchdog_run(watchdog_run),
    .digital_input_enable(digital_input_enable), .misc_ctrl(misc_ctrl));
  cpu_side_model i_cpu (.clk(clk), .sleep_req(sleep_req), .wake_req(wake_req), .clk_en_cpu(clk_en_cpu),
    .sleep_exec(sleep_exec), .external_line_zero_level(ext_lvl));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (converter_auto_start) auto_seen <= 1'b1;
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic do_sleep();
    @(posedge clk) sleep_req <= 1'b1;
    @(posedge clk) sleep_req <= 1'b0;
  endtask
  task automatic t_regs();
    apb(0, sleep_gating_pkg::CTRL_ADDR, 0);
    chk("ctrl reset", 32'h0, rd);
    apb(1, sleep_gating_pkg::CTRL_ADDR, 32'hffffffff);
    apb(0, sleep_gating_pkg::CTRL_ADDR, 0);
    chk("ctrl readback", 32'h7b, rd);
    chk("misc bits", 32'h7, misc_ctrl);
    apb(1, sleep_gating_pkg::GATE_ADDR, 32'hffffffff);
    apb(0, sleep_gating_pkg::GATE_ADDR, 0);
    chk("gate readback", 32'h0f, rd);
    apb(0, 10'h000, 0);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped error", 32'h1, serr);
    apb(1, sleep_gating_pkg::CTRL_ADDR, 0);
    apb(1, sleep_gating_pkg::GATE_ADDR, 0);
  endtask
  task automatic t_noop();
    apb(1, sleep_gating_pkg::CTRL_ADDR, 32'h10);
    do_sleep();
    settle(3);
    chk("unarmed clocks", 32'h3, {clk_en_cpu, osc_enable});
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      apb(1, sleep_gating_pkg::CTRL_ADDR, 32'h20 | (m << 3));
      auto_seen = 1'b0;
      do_sleep();
      settle(3);
      chk("mode clocks", EXP_EN[m], {clk_en_cpu, clk_en_flash, clk_en_io, clk_en_converter, osc_enable});
      chk("auto start", m == 1, auto_seen);
      chk("comparator", m < 2, comparator_active);
      chk("input buffers", m < 2, digital_input_enable);
      chk("kept on", 32'h7, {reference_enable, brownout_active, watchdog_run});
      if (m > 0) begin
        @(posedge clk) any_irq <= 1'b1;
        settle(4);
        chk("no wake by other irq", 32'h0, clk_en_cpu);
        @(posedge clk) any_irq <= 1'b0;
      end
      @(posedge clk);
      if (m == 0) any_irq <= 1'b1;
      else wake_req <= 1'b1;
      t[m] = 0;
      do begin
        @(negedge clk);
        t[m]++;
      end while (cpu_resume !== 1'b1 && t[m] < 100);
      @(posedge clk);
      any_irq <= 1'b0;
      wake_req <= 1'b0;
      apb(1, sleep_gating_pkg::CTRL_ADDR, 0);
      settle(6);
    end
    chk("idle wake", sleep_gating_pkg::WAKE_HALT_CYCLES + 2, t[0]);
    chk("power-down wake", t[1] + 2, t[2]);
    chk("standby wake", t[1] + sleep_gating_pkg::STANDBY_WAKE_CYCLES, t[3]);
  endtask
  task automatic t_gating();
    @(posedge clk) converter_enabled <= 1'b0;
    settle(2);
    chk("extended next", 32'h1, converter_extended_next);
    // A conversion start uses up the extended-conversion mark
    @(posedge clk) conv_start <= 1'b1;
    @(posedge clk) conv_start <= 1'b0;
    settle(1);
    chk("extended cleared", 32'h0, converter_extended_next);
    apb(1, sleep_gating_pkg::GATE_ADDR, 32'h0f);
    settle(3);
    chk("gated clocks", 32'h0, {clk_en_timer_one, clk_en_timer_zero, clk_en_serial, clk_en_converter});
    chk("access block", 32'hf, periph_access_block);
    apb(1, sleep_gating_pkg::GATE_ADDR, 32'h0);
    settle(3);
    chk("ungated clocks", 32'hf, {clk_en_timer_one, clk_en_timer_zero, clk_en_serial, clk_en_converter});
    chk("access open", 32'h0, periph_access_block);
    // With fuse, watchdog and converter off and no comparator reference, all must drop
    @(posedge clk) {brownout_level_fuse, watchdog_enabled} <= 2'b00;
    settle(2);
    chk("supervisors off", 32'h0, {reference_enable, brownout_active, watchdog_run});
  endtask
  initial begin
    {psel, penable, pwrite, sleep_req, wake_req, any_irq, auto_seen, conv_start} = '0;
    paddr = 10'h000;
    pwdata = 32'h0;
    {crystal_selected, converter_enabled, comparator_enabled, brownout_level_fuse, watchdog_enabled} = 5'h1f;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_noop();
    t_modes();
    t_gating();
    complete_run();
  end
endmodule
`default_nettype wire
